/* File: hdl/hms_top.sv */
// harvester mode sequencer: mode machine, switch gating, status, apb
// Behaviour
// - leave deep sleep on cold-start threshold
// - wake-up: regulators off, ready pin low
// - cut aux start link at rails ready
// - charge with regulators off, then normal
// - storage already ready: skip charging
// - regulators follow enable pins when permitted
// - normal between levels; overcharge above full
// - overcharge: converter pulsed, outputs stay available
// - overcharge idle: source isolation switch open
// - normal: storage switch closed; open on depletion
// - primary usable only if quarter exceeds ref
// - primary mode: isolate source, close primary, low-energy high
// - primary mode exits at charge-ready level
// - no primary: shutdown, warn, grace interval
// - recovery within grace returns to normal
// - grace expiry: deep sleep, all off except aux start link, which follows the control bit
// - periodic open-circuit sampling opens source switch
// - fixed sampling window and period
// - sampling pin high during evaluation
//
// Local design decisions: register access over APB and the address map.
`timescale 1ns/1ps
module hms_top #(
  parameter int unsigned GRACE_CYCLES = 32'(hms_pkg::GRACE_CYC),
  parameter int unsigned SAMPLE_CYCLES = 32'(hms_pkg::SAMPLE_CYC),
  parameter int unsigned PERIOD_CYCLES = 32'(hms_pkg::PERIOD_CYC)
) (
  input wire logic clock_i,
  input wire logic rstn_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // comparator flags, asynchronous
  input wire logic cold_start_ok_i,
  input wire logic rails_ready_i,
  input wire logic above_full_i,
  input wire logic above_ready_i,
  input wire logic above_depletion_i,
  input wire logic primary_cell_input_quarter_gt_ref_i,
  input wire logic conv_demand_i,
  // application enables
  input wire logic low_rail_enable_i,
  input wire logic high_rail_enable_i,
  // gating outputs
  output logic low_rail_output_o,
  output logic high_rail_output_o,
  output logic source_isolation_switch_o,
  output logic storage_switch_o,
  output logic primary_cell_switch_o,
  output logic aux_start_link_o,
  output logic converter_on_o,
  // status pins
  output logic outputs_ready_o,
  output logic low_energy_o,
  output logic sampling_o
);

  // ----------------------------------------------------------------
  // flag synchronisation
  // ----------------------------------------------------------------
  logic [hms_pkg::FLG_N-1:0] flag_raw;
  logic [hms_pkg::FLG_N-1:0] flag;

  assign flag_raw = {conv_demand_i, primary_cell_input_quarter_gt_ref_i, above_depletion_i,
                     above_ready_i, above_full_i, rails_ready_i, cold_start_ok_i};

  // all comparator results pass two flops
  hms_sync #(
    .W(hms_pkg::FLG_N)
  ) u_sync (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .async_i(flag_raw),
    .sync_o(flag)
  );

  logic f_cold, f_rails, f_full, f_rdy, f_depl, f_primary_cell_input, f_conv;
  assign f_cold = flag[hms_pkg::FLG_COLD];
  assign f_rails = flag[hms_pkg::FLG_RAILS];
  assign f_full = flag[hms_pkg::FLG_FULL];
  assign f_rdy = flag[hms_pkg::FLG_RDY];
  assign f_depl = flag[hms_pkg::FLG_DEPL];
  assign f_primary_cell_input = flag[hms_pkg::FLG_PRIMARY_CELL_INPUT];
  assign f_conv = flag[hms_pkg::FLG_CONV];

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    hms_pkg::hms_mode_t mode;
    logic [hms_pkg::CNT_W-1:0] grace_cnt;
    logic [hms_pkg::CNT_W-1:0] period_cnt;
    logic [hms_pkg::CNT_W-1:0] sample_cnt;
    logic sampling;
    logic [15:0] trk_count;
    logic aux_used;
    logic aux_link;
    logic lv_out;
    logic hv_out;
    logic iso_sw;
    logic sto_sw;
    logic primary_cell_input_sw;
    logic conv;
    logic ready;
    logic low_e;
    logic [31:0] rdata;
    logic pready;
    logic pslverr;
  } hms_state_t;

  hms_state_t st_r;
  hms_state_t st_nxt;

  logic apb_setup;
  assign apb_setup = psel_i && !penable_i;

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic permit;
    logic grace_done;
    logic sample_end;
    permit = 1'b0;
    grace_done = 1'b0;
    sample_end = 1'b0;
    st_nxt = st_r;
    st_nxt.pready = 1'b0;
    st_nxt.pslverr = 1'b0;

    // mode machine
    case (st_r.mode)
      hms_pkg::HMS_SLEEP: begin
        st_nxt.aux_link = st_r.aux_used;
        if (f_cold) begin
          st_nxt.mode = hms_pkg::HMS_WAKE;
        end
      end
      hms_pkg::HMS_WAKE: begin
        if (f_rails) begin
          st_nxt.aux_link = 1'b0;
          if (f_rdy) begin
            st_nxt.mode = hms_pkg::HMS_NORMAL;
          end else begin
            st_nxt.mode = hms_pkg::HMS_CHARGE;
          end
        end
      end
      hms_pkg::HMS_CHARGE: begin
        if (f_rdy) begin
          st_nxt.mode = hms_pkg::HMS_NORMAL;
        end
      end
      hms_pkg::HMS_NORMAL: begin
        if (!f_depl) begin
          // depletion: primary or shutdown
          if (f_primary_cell_input) begin
            st_nxt.mode = hms_pkg::HMS_PRIMARY_CELL_INPUT;
          end else begin
            st_nxt.mode = hms_pkg::HMS_SHUT;
            st_nxt.grace_cnt = '0;
          end
        end else if (f_full) begin
          st_nxt.mode = hms_pkg::HMS_OVER;
        end
      end
      hms_pkg::HMS_OVER: begin
        if (!f_full) begin
          st_nxt.mode = hms_pkg::HMS_NORMAL;
        end
      end
      hms_pkg::HMS_PRIMARY_CELL_INPUT: begin
        if (f_rdy) begin
          st_nxt.mode = hms_pkg::HMS_NORMAL;
        end
      end
      hms_pkg::HMS_SHUT: begin
        grace_done = (st_r.grace_cnt >= GRACE_CYCLES - 1);
        st_nxt.grace_cnt = st_r.grace_cnt + 1'b1;
        if (f_depl) begin
          st_nxt.mode = hms_pkg::HMS_NORMAL;
        end else if (grace_done) begin
          st_nxt.mode = hms_pkg::HMS_SLEEP;
        end
      end
      default: begin
        st_nxt.mode = hms_pkg::HMS_SLEEP;
      end
    endcase

    // periodic open-circuit sampling in normal and shutdown modes
    if (st_nxt.mode == hms_pkg::HMS_NORMAL || st_nxt.mode == hms_pkg::HMS_SHUT) begin
      if (st_r.period_cnt >= PERIOD_CYCLES - 1) begin
        st_nxt.period_cnt = '0;
        st_nxt.sampling = 1'b1;
        st_nxt.sample_cnt = '0;
      end else begin
        st_nxt.period_cnt = st_r.period_cnt + 1'b1;
      end
      if (st_r.sampling) begin
        sample_end = (st_r.sample_cnt >= SAMPLE_CYCLES - 1);
        st_nxt.sample_cnt = st_r.sample_cnt + 1'b1;
        if (sample_end) begin
          st_nxt.sampling = 1'b0;
          st_nxt.trk_count = st_r.trk_count + 1'b1; // new target taken
        end
      end
    end else begin
      st_nxt.period_cnt = '0;
      st_nxt.sample_cnt = '0;
      st_nxt.sampling = 1'b0;
    end

    // output gating from next mode
    permit = (st_nxt.mode == hms_pkg::HMS_NORMAL) || (st_nxt.mode == hms_pkg::HMS_OVER)
          || (st_nxt.mode == hms_pkg::HMS_PRIMARY_CELL_INPUT) || (st_nxt.mode == hms_pkg::HMS_SHUT);
    // held off in sleep, wake and charge
    st_nxt.lv_out = permit && low_rail_enable_i;
    st_nxt.hv_out = permit && high_rail_enable_i;
    st_nxt.ready = permit;
    st_nxt.low_e = (st_nxt.mode == hms_pkg::HMS_PRIMARY_CELL_INPUT) || (st_nxt.mode == hms_pkg::HMS_SHUT);
    // storage linked in wake, charge, normal and overcharge
    st_nxt.sto_sw = (st_nxt.mode == hms_pkg::HMS_NORMAL) || (st_nxt.mode == hms_pkg::HMS_OVER)
                 || (st_nxt.mode == hms_pkg::HMS_CHARGE) || (st_nxt.mode == hms_pkg::HMS_WAKE);
    st_nxt.primary_cell_input_sw = (st_nxt.mode == hms_pkg::HMS_PRIMARY_CELL_INPUT);
    // converter pulses on demand in every mode but sleep, held off while sampling
    st_nxt.conv = (st_nxt.mode != hms_pkg::HMS_SLEEP) && !st_nxt.sampling && f_conv;
    case (st_nxt.mode)
      hms_pkg::HMS_SLEEP: st_nxt.iso_sw = 1'b0;
      hms_pkg::HMS_PRIMARY_CELL_INPUT: st_nxt.iso_sw = 1'b0;
      hms_pkg::HMS_OVER: st_nxt.iso_sw = st_nxt.conv;
      default: st_nxt.iso_sw = !st_nxt.sampling;
    endcase

    // apb access phase, answered after one wait cycle
    if (psel_i && penable_i && !st_r.pready) begin
      st_nxt.pready = 1'b1;
      if (pwrite_i) begin
        if (paddr_i == hms_pkg::CTRL_OFS) begin
          st_nxt.aux_used = pwdata_i[hms_pkg::CTRL_AUX_BIT];
        end else begin
          st_nxt.pslverr = 1'b1;
        end
      end else begin
        if (paddr_i == hms_pkg::CTRL_OFS) begin
          st_nxt.rdata = {31'h0, st_r.aux_used};
        end else if (paddr_i == hms_pkg::STAT_OFS) begin
          st_nxt.rdata = {20'h0, st_r.sampling, st_r.low_e, st_r.ready, st_r.aux_link,
                          st_r.primary_cell_input_sw, st_r.sto_sw, st_r.iso_sw, st_r.conv, 1'b0,
                          st_r.mode};
        end else if (paddr_i == hms_pkg::TRK_OFS) begin
          st_nxt.rdata = {16'h0, st_r.trk_count};
        end else begin
          st_nxt.rdata = 32'h0000_0000;
          st_nxt.pslverr = 1'b1;
        end
      end
    end else if (apb_setup) begin
      st_nxt.rdata = 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_r <= '0;
      st_r.mode <= hms_pkg::HMS_SLEEP;
      st_r.aux_used <= hms_pkg::CTRL_RST[hms_pkg::CTRL_AUX_BIT];
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from flops
  assign prdata_o = st_r.rdata;
  assign pready_o = st_r.pready;
  assign pslverr_o = st_r.pslverr;
  assign low_rail_output_o = st_r.lv_out;
  assign high_rail_output_o = st_r.hv_out;
  assign source_isolation_switch_o = st_r.iso_sw;
  assign storage_switch_o = st_r.sto_sw;
  assign primary_cell_switch_o = st_r.primary_cell_input_sw;
  assign aux_start_link_o = st_r.aux_link;
  assign converter_on_o = st_r.conv;
  assign outputs_ready_o = st_r.ready;
  assign low_energy_o = st_r.low_e;
  assign sampling_o = st_r.sampling;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_enter_shut;
    st_r.mode == hms_pkg::HMS_NORMAL ##1 st_r.mode == hms_pkg::HMS_SHUT;
  endsequence

  a_wake_outputs_off: assert property (@(posedge clock_i) disable iff (!rstn_i)
    (st_r.mode == hms_pkg::HMS_WAKE || st_r.mode == hms_pkg::HMS_CHARGE)
    |-> !outputs_ready_o && !low_rail_output_o && !high_rail_output_o)
    else $error("regulators on during wake-up");

  a_sleep_leave: assert property (@(posedge clock_i) disable iff (!rstn_i)
    st_r.mode == hms_pkg::HMS_SLEEP && f_cold |=> st_r.mode == hms_pkg::HMS_WAKE)
    else $error("sleep not left on cold start");

  a_follow_enable: assert property (@(posedge clock_i) disable iff (!rstn_i)
    st_r.mode == hms_pkg::HMS_NORMAL && $past(st_r.mode) == hms_pkg::HMS_NORMAL
    |-> low_rail_output_o == $past(low_rail_enable_i))
    else $error("low rail not following enable");

  a_over_iso_open: assert property (@(posedge clock_i) disable iff (!rstn_i)
    st_r.mode == hms_pkg::HMS_OVER && !converter_on_o |-> !source_isolation_switch_o)
    else $error("source switch closed while idle in overcharge");

  a_primary_cell_input_switches: assert property (@(posedge clock_i) disable iff (!rstn_i)
    st_r.mode == hms_pkg::HMS_PRIMARY_CELL_INPUT
    |-> primary_cell_switch_o && !source_isolation_switch_o && low_energy_o)
    else $error("primary mode switches wrong");

  a_shut_warn: assert property (@(posedge clock_i) disable iff (!rstn_i)
    s_enter_shut |-> low_energy_o && !storage_switch_o)
    else $error("shutdown entry without warning");

  a_shut_recover: assert property (@(posedge clock_i) disable iff (!rstn_i)
    st_r.mode == hms_pkg::HMS_SHUT && f_depl |=> st_r.mode == hms_pkg::HMS_NORMAL)
    else $error("no recovery from shutdown");

  a_grace_len: assert property (@(posedge clock_i) disable iff (!rstn_i)
    st_r.mode == hms_pkg::HMS_SHUT && !f_depl && st_r.grace_cnt < GRACE_CYCLES - 1
    |=> st_r.mode == hms_pkg::HMS_SHUT && high_rail_output_o == $past(high_rail_enable_i))
    else $error("shutdown left or rail dropped before grace end");

  a_sleep_all_off: assert property (@(posedge clock_i) disable iff (!rstn_i)
    $past(st_r.mode) == hms_pkg::HMS_SHUT && st_r.mode == hms_pkg::HMS_SLEEP
    |-> $past(st_r.grace_cnt) >= GRACE_CYCLES - 1 && !storage_switch_o && !outputs_ready_o)
    else $error("deep sleep before grace end or outputs left on");

  a_sample_iso: assert property (@(posedge clock_i) disable iff (!rstn_i)
    sampling_o |-> !source_isolation_switch_o && !converter_on_o)
    else $error("source connected during sampling");

  a_aux_cut: assert property (@(posedge clock_i) disable iff (!rstn_i)
    st_r.mode == hms_pkg::HMS_WAKE && f_rails |=> !aux_start_link_o)
    else $error("aux link kept after rails ready");

endmodule

/* File: hdl/hms_pkg.sv */
// package: constants and types for the harvester mode sequencer
package hms_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned GRACE_MS = 600;
  localparam int unsigned SAMPLE_MS = 328;
  localparam int unsigned PERIOD_S = 21;
  localparam longint unsigned GRACE_CYC = longint'(GRACE_MS) * CLK_HZ / 1000;
  localparam longint unsigned SAMPLE_CYC = longint'(SAMPLE_MS) * CLK_HZ / 1000;
  localparam longint unsigned PERIOD_CYC = longint'(PERIOD_S) * CLK_HZ;
  localparam int CNT_W = 32;

  // ----------------------------------------------------------------
  // apb register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] TRK_OFS = 8'h08;
  localparam int CTRL_AUX_BIT = 0;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;

  // ----------------------------------------------------------------
  // comparator flag order
  // ----------------------------------------------------------------
  localparam int FLG_COLD = 0;
  localparam int FLG_RAILS = 1;
  localparam int FLG_FULL = 2;
  localparam int FLG_RDY = 3;
  localparam int FLG_DEPL = 4;
  localparam int FLG_PRIMARY_CELL_INPUT = 5;
  localparam int FLG_CONV = 6;
  localparam int FLG_N = 7;

  // operating modes
  typedef enum logic [2:0] {
    HMS_SLEEP,
    HMS_WAKE,
    HMS_CHARGE,
    HMS_NORMAL,
    HMS_OVER,
    HMS_PRIMARY_CELL_INPUT,
    HMS_SHUT
  } hms_mode_t;

endpackage

/* File: hdl/hms_sync.sv */
// two flip-flop synchroniser bank for comparator flags
`timescale 1ns/1ps
module hms_sync #(
  parameter int W = 7
) (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  // ----------------------------------------------------------------
  // per-bit synchroniser
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      logic meta_r;
      logic hold_r;
      // first stage read only by second stage
      always_ff @(posedge clock_i or negedge rstn_i) begin
        if (!rstn_i) begin
          meta_r <= 1'b0;
          hold_r <= 1'b0;
        end else begin
          meta_r <= async_i[g];
          hold_r <= meta_r;
        end
      end
      assign sync_o[g] = hold_r;
    end
  endgenerate

endmodule

/* File: dv/hms_app_model.sv */
// application microcontroller model: drives regulator enables, watches the low-energy pin
`timescale 1ns/1ps
module hms_app_model (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic [1:0] want_i,
  input wire logic slow_i,
  input wire logic low_energy_i,
  output logic low_rail_enable_o,
  output logic high_rail_enable_o,
  output logic saved_o
);
  logic [2:0] wait_r;
  logic low_q_r;

  // enables follow the wanted pattern, promptly or after a few cycles
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wait_r <= 3'h0;
      low_q_r <= 1'b0;
      saved_o <= 1'b0;
      {high_rail_enable_o, low_rail_enable_o} <= 2'h0;
    end else begin
      low_q_r <= low_energy_i;
      if ({high_rail_enable_o, low_rail_enable_o} == want_i) begin
        wait_r <= slow_i ? 3'h3 : 3'h0;
      end else if (wait_r == 3'h0) begin
        {high_rail_enable_o, low_rail_enable_o} <= want_i;
      end else begin
        wait_r <= wait_r - 3'h1;
      end
      // protective action taken at the warning edge, well inside the grace span
      if (low_energy_i && !low_q_r) begin
        saved_o <= 1'b1;
      end else if (!low_energy_i) begin
        saved_o <= 1'b0;
      end
    end
  end
endmodule

/* File: dv/harvester_mode_sequencer_test.sv */
// self-checking bench for the harvester mode sequencer
`timescale 1ns/1ps
module harvester_mode_sequencer_test;
  typedef struct {logic [31:0] exp; logic [31:0] msk; logic err;} hms_note_t;
  localparam int GR = 20;
  localparam logic [31:0] MK = 32'hFFFF_F7CF;
  logic clock_i = 1'b0, rstn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, slow = 1'b0, cv;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rq;
  logic pready, pslverr, lo_en, hi_en, lo_out, hi_out, iso, sto, pri, conv, low, smp, saved;
  logic rdy_pin, aux;
  logic [6:0] flg = 7'h00; // bits: cold, rails, full, ready, depl, primary_cell_input, conv demand
  logic [1:0] want = 2'h0;
  hms_note_t notes[$];
  hms_note_t nt;
  int fail_count = 0, total_checks = 0, n, m;

  always #5 clock_i = ~clock_i;

  hms_top #(.GRACE_CYCLES(GR), .SAMPLE_CYCLES(5), .PERIOD_CYCLES(40)) dut (
    .clock_i(clock_i), .rstn_i(rstn), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .cold_start_ok_i(flg[0]),
    .rails_ready_i(flg[1]), .above_full_i(flg[2]), .above_ready_i(flg[3]),
    .above_depletion_i(flg[4]), .primary_cell_input_quarter_gt_ref_i(flg[5]), .conv_demand_i(flg[6]),
    .low_rail_enable_i(lo_en), .high_rail_enable_i(hi_en), .low_rail_output_o(lo_out),
    .high_rail_output_o(hi_out), .source_isolation_switch_o(iso), .storage_switch_o(sto),
    .primary_cell_switch_o(pri), .aux_start_link_o(aux), .converter_on_o(conv),
    .outputs_ready_o(rdy_pin), .low_energy_o(low), .sampling_o(smp));

  hms_app_model app (.clock_i(clock_i), .rstn_i(rstn), .want_i(want), .slow_i(slow),
    .low_energy_i(low), .low_rail_enable_o(lo_en), .high_rail_enable_o(hi_en),
    .saved_o(saved));

  // ----------------------------------------------------------------
  // checking and bus tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // one apb transfer: setup, access held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clock_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clock_i);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rq = prdata;
    if (k >= 50) fail_count++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] mk,
                    input logic er);
    notes.push_back('{e, mk, er});
    apb(1'b0, a, 32'h0000_0000);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic er);
    notes.push_back('{32'h0000_0000, 32'h0000_0000, er});
    apb(1'b1, a, d);
  endtask

  // new comparator levels, then let the synchroniser and mode register settle
  task automatic setf(input logic [6:0] f);
    @(posedge clock_i);
    flg <= f;
    repeat (4) @(posedge clock_i);
    #1;
  endtask

  // compare each bus answer against the oldest note
  always @(negedge clock_i) begin
    if (pready === 1'b1) begin
      if (notes.size() == 0) begin
        check("unexpected answer", 32'h0000_0001, 32'h0000_0000);
      end else begin
        nt = notes.pop_front();
        check("read data", prdata & nt.msk, nt.exp & nt.msk);
        check("slave error", 32'(pslverr), 32'(nt.err));
      end
    end
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(86));
    repeat (5) @(posedge clock_i);
    rstn <= 1'b1;
    rd(hms_pkg::STAT_OFS, 32'h0000_0000, MK, 1'b0);
    wr(hms_pkg::CTRL_OFS, 32'h0000_0001, 1'b0);
    rd(hms_pkg::CTRL_OFS, 32'h0000_0001, 32'hFFFF_FFFF, 1'b0);
    wr(hms_pkg::STAT_OFS, 32'h0000_0001, 1'b1);
    rd(8'h10, 32'h0000_0000, 32'hFFFF_FFFF, 1'b1);
    want <= 2'h3;
    setf(7'h01);
    check("rails in wake", 32'({hi_out, lo_out}), 32'h0);
    check("ready pin in wake", 32'(rdy_pin), 32'h0);
    check("aux link in wake", 32'(aux), 32'h1);
    rd(hms_pkg::STAT_OFS, 32'h0000_0141, MK, 1'b0);
    setf(7'h03);
    check("rails in charge", 32'({hi_out, lo_out}), 32'h0);
    check("ready pin in charge", 32'(rdy_pin), 32'h0);
    check("aux link cut", 32'(aux), 32'h0);
    rd(hms_pkg::STAT_OFS, 32'h0000_0042, MK, 1'b0);
    setf(7'h1B);
    rd(hms_pkg::STAT_OFS, 32'h0000_0243, MK, 1'b0);
    check("ready pin in normal", 32'(rdy_pin), 32'h1);
    // enables toggled at random, model prompt or slow
    for (int i = 0; i < 8; i++) begin
      @(posedge clock_i);
      want <= 2'($urandom);
      slow <= 1'($urandom);
      repeat (10) @(posedge clock_i);
      #1;
      check("rails follow enables", 32'({hi_out, lo_out}), 32'(want));
    end
    // open-circuit sampling window length and period; skip a window already open
    n = 0;
    while (smp === 1'b1 && n < 20) begin
      @(posedge clock_i);
      n++;
    end
    n = 0;
    while (smp !== 1'b1 && n < 200) begin
      @(posedge clock_i);
      n++;
    end
    n = 0;
    while (smp === 1'b1 && n < 100) begin
      if (n == 2) check("source switch in sampling", 32'(iso), 32'h0);
      @(posedge clock_i);
      n++;
    end
    m = 0;
    while (smp !== 1'b1 && m < 100) begin
      @(posedge clock_i);
      m++;
    end
    check("sampling length", 32'(n), 32'h0000_0005);
    check("sampling period", 32'(n + m), 32'h0000_0028);
    setf(7'h1F);
    rd(hms_pkg::STAT_OFS, 32'h0000_0204, 32'hFFFF_F78F, 1'b0);
    for (int i = 0; i < 6; i++) begin
      cv = 1'($urandom);
      setf({cv, 6'h1F});
      check("converter", 32'(conv), 32'(cv));
      if (!cv) check("source switch idle", 32'(iso), 32'h0);
      check("rails in overcharge", 32'({hi_out, lo_out}), 32'(want));
    end
    setf(7'h1B);
    rd(hms_pkg::STAT_OFS, 32'h0000_0243, MK, 1'b0);
    setf(7'h23);
    rd(hms_pkg::STAT_OFS, 32'h0000_0485, 32'hFFFF_F5CF, 1'b0);
    setf(7'h33);
    check("low energy in primary", 32'(low), 32'h1);
    check("primary switch", 32'(pri), 32'h1);
    check("source switch in primary", 32'(iso), 32'h0);
    setf(7'h3B);
    rd(hms_pkg::STAT_OFS, 32'h0000_0243, MK, 1'b0);
    want <= 2'h3;
    setf(7'h03);
    rd(hms_pkg::STAT_OFS, 32'h0000_0406, 32'hFFFF_F5CF, 1'b0);
    check("rails in shutdown", 32'({hi_out, lo_out}), 32'h3);
    check("application warned", 32'(saved), 32'h1);
    setf(7'h13);
    rd(hms_pkg::STAT_OFS, 32'h0000_0243, MK, 1'b0);
    setf(7'h02);
    // shutdown entered one edge before setf returns; last grace cycle next
    repeat (GR - 2) @(posedge clock_i);
    #1;
    check("rails in grace", 32'({hi_out, lo_out}), 32'h3);
    repeat (1) @(posedge clock_i);
    #1;
    check("rails after grace", 32'({hi_out, lo_out}), 32'h0);
    check("storage after grace", 32'(sto), 32'h0);
    rd(hms_pkg::STAT_OFS, 32'h0000_0000, 32'hFFFF_F6CF, 1'b0);
    // storage already charged at wake-up
    setf(7'h1A);
    setf(7'h1B);
    n = 0;
    do begin
      rd(hms_pkg::STAT_OFS, 32'h0000_0000, 32'h0000_0000, 1'b0);
      n++;
    end while (rq[2:0] inside {3'h0, 3'h1} && n < 20);
    check("mode after wake", 32'(rq[2:0]), 32'h3);
    give_verdict();
  end

  // watchdog
  initial begin
    repeat (5000) @(posedge clock_i);
    fail_count++;
    give_verdict();
  end
endmodule
